// ===== verilog/arw_pkg.sv
package arw_pkg;
    localparam int DATA_W = 8;
    localparam int QUEUE_DEPTH = 3;
    localparam int STAT_W = 3;
    // Status slot positions inside a queue entry
    localparam int STAT_PAR = 0;
    localparam int STAT_FRM = 1;
    localparam int STAT_BRK = 2;
    // Parity mode field encodings
    localparam logic [1:0] PMODE_WITH = 2'h0;
    localparam logic [1:0] PMODE_FORCE = 2'h1;
    localparam logic [1:0] PMODE_NONE = 2'h2;
    localparam logic [1:0] PMODE_WAKEUP = 2'h3;
    localparam int MIN_DATA_BITS = 5;
    // Bit timing in half periods of the 16X clock
    localparam int START_HALF_TICKS = 15;
    localparam int BIT_HALF_TICKS = 32;
    localparam int HALFBIT_HALF_TICKS = 16;
    localparam int BREAK_END_EDGES = 2;
    localparam int COS_SAMPLES = 2;
    localparam logic COS_PIN_RESET = 1'b1;
    localparam logic [4:0] TICK_ZERO = 5'h00;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [2:0] STAT_ZERO = 3'h0;
    localparam logic [1:0] PTR_ZERO = 2'h0;
    localparam logic [1:0] PTR_LAST = 2'h2;
endpackage : arw_pkg

// ===== verilog/arw_cos_detect.sv
`timescale 1ns/10ps
module arw_cos_detect (
    input wire logic clk_in, // System clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic pin_in, // Multipurpose input level
    input wire logic enable_in, // Pin used as clear-to-send or general input
    input wire logic sample_in, // 38.4kHz sampling strobe
    input wire logic clear_in, // Clear command
    output logic change_out // Sticky change-of-state bit
);
    import arw_pkg::*;
    logic smp_a_reg;
    logic level_reg;
    logic change_reg;
    wire confirmed = sample_in && enable_in && (smp_a_reg == pin_in) && (pin_in != level_reg);

    // Two successive samples at the new level are needed, so a glitch between strobes is ignored
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            smp_a_reg <= COS_PIN_RESET;
            level_reg <= COS_PIN_RESET;
        end else if (sample_in) begin
            smp_a_reg <= pin_in;
            if (confirmed) begin
                level_reg <= pin_in;
            end
        end
    end

    // Set beats a simultaneous clear
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            change_reg <= 1'b0;
        end else begin
            change_reg <= confirmed | (change_reg & ~clear_in);
        end
    end

    assign change_out = change_reg;
endmodule : arw_cos_detect

// ===== verilog/arw_receiver.sv
`timescale 1ns/10ps
// What this block does
// - Recheck start bit at 7.5 16X clocks
// - Sample bit centres, assemble, queue, flag available
// - Unused upper data bits stored as zero
// - Search next start right after stop
// - Low half-bit after framing error restarts
// - Error flags latched on the same clock as the available flag rises
// - Full-low character stores one zero, break
// - Break ends after two high crystal edges
// - Three-deep queue, fill top-most empty slot
// - Available and full flags, selectable interrupt
// - Holding read returns head, then pops
// - Per-entry status; character or block mode
// - Status reads never change the queue
// - Auto negate send request on a valid start bit while full
// - Disable drops partial character except in wake-up mode, keeps queue
// - Reset clears available and full flags, realigns pointers, keeps data
// - Parity mode 11 selects wake-up mode
// - Address/data flag replaces parity bit
// - Disabled wake-up queues only address characters
// - Address flag stored in parity slot
// - Confirmed input change sets status bit
// - Mode bit picks interrupt source
// - Mode bit picks character or block status
// - Control bit enables automatic send request negation
module arw_receiver (
    input wire logic CLK_SYS_IN, // 50 MHz system clock
    input wire logic RST_B_IN, // Async reset, active low
    input wire logic RXD_IN, // Serial receive line
    input wire logic RX_CLK16_IN, // 16X bit clock level
    input wire logic RX_CLK1X_IN, // 1X bit clock level
    input wire logic CLK_MODE_1X_IN, // 1 selects 1X clock mode
    input wire logic CRYSTAL_EDGE_IN, // Pulse on each crystal clock edge
    input wire logic [1:0] BITS_PER_CHAR_IN, // 0..3 = 5..8 data bits
    input wire logic [1:0] PARITY_MODE_IN, // Parity mode field
    input wire logic PARITY_TYPE_IN, // 1 odd parity / forced parity value; unused in wake-up mode
    input wire logic ERROR_MODE_BLOCK_IN, // 1 block status mode
    input wire logic RX_INT_SELECT_IN, // 1 interrupt on queue full
    input wire logic RX_RTS_CTRL_IN, // Automatic send request control
    input wire logic RX_ENABLE_IN, // Receiver enable level
    input wire logic RX_RESET_CMD_IN, // Receiver reset command pulse
    input wire logic ERROR_RESET_CMD_IN, // Reset error status command pulse
    input wire logic RTS_ASSERT_CMD_IN, // Assert send request command pulse
    input wire logic RTS_NEGATE_CMD_IN, // Negate send request command pulse
    input wire logic RX_READ_IN, // Holding queue read pulse
    input wire logic MULTI_INPUT_PIN_IN, // Multipurpose input pin
    input wire logic COS_ENABLE_IN, // Pin used as clear-to-send or general input
    input wire logic SAMPLE_38K_IN, // 38.4kHz sampling strobe
    input wire logic COS_CLEAR_CMD_IN, // Clear change-of-state command pulse
    input wire logic COS_MASK_IN, // Change-of-state interrupt mask
    output logic [arw_pkg::DATA_W-1:0] RX_DATA_OUT, // Head of holding queue
    output logic RX_CHAR_AVAILABLE_OUT, // At least one character queued
    output logic RX_QUEUE_FULL_OUT, // All three slots filled
    output logic OVERRUN_OUT, // Overrun error
    output logic PARITY_ERROR_FLAG_OUT, // Parity error or address flag
    output logic FRAMING_ERROR_FLAG_OUT, // Framing error
    output logic RX_BREAK_OUT, // Received break
    output logic RX_INT_REQ_OUT, // Receiver interrupt request
    output logic REQUEST_TO_SEND_B_OUT, // Send request, active low
    output logic COS_STATUS_OUT, // Change-of-state status bit
    output logic COS_INT_OUT // Masked change-of-state interrupt
);
    import arw_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP, ST_HALF, ST_BREAK} arw_state_t;

    function automatic logic [4:0] half_ticks(input int n);
        half_ticks = 5'(n - 1);
    endfunction : half_ticks

    arw_state_t state_reg;
    arw_state_t state_next;
    logic rxd_prev_reg;
    logic clk16_prev_reg;
    logic clk1x_prev_reg;
    logic [4:0] tick_reg;
    logic [3:0] bit_idx_reg;
    logic [DATA_W-1:0] shift_reg;
    logic par_bit_reg;
    logic [1:0] brk_cnt_reg;
    logic [DATA_W-1:0] data_mem [QUEUE_DEPTH];
    logic [STAT_W-1:0] stat_mem [QUEUE_DEPTH];
    logic [1:0] rd_ptr_reg;
    logic [1:0] wr_ptr_reg;
    logic [1:0] count_reg;
    logic [STAT_W-1:0] block_acc_reg;
    logic overrun_reg;
    logic rts_on_reg;
    logic auto_neg_reg;
    logic [DATA_W-1:0] rx_data_reg;

    wire wake_mode = (PARITY_MODE_IN == PMODE_WAKEUP);
    wire has_par = (PARITY_MODE_IN != PMODE_NONE);
    wire [3:0] n_data = 4'(MIN_DATA_BITS) + {2'h0, BITS_PER_CHAR_IN};
    wire [3:0] n_frame = n_data + {3'h0, has_par};
    // Disabled receiver only keeps running in wake-up mode, to spot addresses
    wire rx_run = RX_ENABLE_IN || wake_mode;
    wire edge16 = RX_CLK16_IN ^ clk16_prev_reg;
    wire rise1x = RX_CLK1X_IN & ~clk1x_prev_reg;
    wire fall1x = ~RX_CLK1X_IN & clk1x_prev_reg;
    wire fall_rxd = rxd_prev_reg & ~RXD_IN;
    wire start_due = CLK_MODE_1X_IN ? rise1x
                   : (edge16 && tick_reg == half_ticks(START_HALF_TICKS));
    wire bit_due = CLK_MODE_1X_IN ? rise1x
                 : (edge16 && tick_reg == half_ticks(BIT_HALF_TICKS));
    wire half_due = CLK_MODE_1X_IN ? fall1x
                  : (edge16 && tick_reg == half_ticks(HALFBIT_HALF_TICKS));
    wire par_expect = (PARITY_MODE_IN == PMODE_WITH) ? (^shift_reg ^ PARITY_TYPE_IN)
                    : PARITY_TYPE_IN;
    wire frame_err = (state_reg == ST_STOP) && bit_due && !RXD_IN;
    wire all_zero = (shift_reg == DATA_ZERO) && !(has_par && par_bit_reg);
    wire is_break = frame_err && all_zero;
    wire char_done = (state_reg == ST_STOP) && bit_due;
    wire keep_char = RX_ENABLE_IN || !wake_mode || par_bit_reg;
    wire push = char_done && keep_char && !RX_RESET_CMD_IN;
    wire full = (count_reg == 2'(QUEUE_DEPTH));
    wire avail = (count_reg != PTR_ZERO);
    wire pop = RX_READ_IN && avail && !RX_RESET_CMD_IN;
    wire push_ok = push && (!full || pop);
    wire start_valid = (state_reg == ST_START) && start_due && !RXD_IN;
    // Parity slot holds the address/data flag in wake-up mode
    wire par_slot = wake_mode ? par_bit_reg : (has_par && par_bit_reg != par_expect);
    wire [STAT_W-1:0] new_stat = {is_break, frame_err, is_break ? 1'b0 : par_slot};
    wire [STAT_W-1:0] head_stat = avail ? stat_mem[rd_ptr_reg] : STAT_ZERO;
    wire [STAT_W-1:0] shown_stat = ERROR_MODE_BLOCK_IN ? (block_acc_reg | head_stat)
                                 : head_stat;

    function automatic logic [1:0] ptr_inc(input logic [1:0] p);
        ptr_inc = (p == PTR_LAST) ? PTR_ZERO : p + 2'h1;
    endfunction : ptr_inc

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (fall_rxd) begin
                    state_next = ST_START;
                end
            end
            ST_START: begin
                if (start_due) begin
                    state_next = RXD_IN ? ST_IDLE : ST_BITS;
                end
            end
            ST_BITS: begin
                if (bit_due && bit_idx_reg == n_frame - 4'h1) begin
                    state_next = ST_STOP;
                end
            end
            ST_STOP: begin
                if (bit_due) begin
                    if (is_break) begin
                        state_next = ST_BREAK;
                    end else if (frame_err) begin
                        state_next = ST_HALF;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_HALF: begin
                if (RXD_IN) begin
                    state_next = ST_IDLE;
                end else if (half_due) begin
                    state_next = ST_START;
                end
            end
            ST_BREAK: begin
                if (brk_cnt_reg == 2'(BREAK_END_EDGES)) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Disable outside wake-up mode, or reset, throws away whatever is being assembled
        if (!rx_run || RX_RESET_CMD_IN) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_reg <= ST_IDLE;
            rxd_prev_reg <= 1'b1;
            clk16_prev_reg <= 1'b0;
            clk1x_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rxd_prev_reg <= RXD_IN;
            clk16_prev_reg <= RX_CLK16_IN;
            clk1x_prev_reg <= RX_CLK1X_IN;
        end
    end

    // Bit timer restarts on each state change so every sample lands mid-bit
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tick_reg <= TICK_ZERO;
        end else if (state_next != state_reg || bit_due) begin
            tick_reg <= TICK_ZERO;
        end else if (edge16) begin
            tick_reg <= tick_reg + 5'h01;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            bit_idx_reg <= 4'h0;
            shift_reg <= DATA_ZERO;
            par_bit_reg <= 1'b0;
        end else if (state_reg != ST_BITS) begin
            bit_idx_reg <= 4'h0;
            if (state_next == ST_BITS) begin
                shift_reg <= DATA_ZERO;
                par_bit_reg <= 1'b0;
            end
        end else if (bit_due) begin
            bit_idx_reg <= bit_idx_reg + 4'h1;
            if (bit_idx_reg < n_data) begin
                shift_reg[bit_idx_reg[2:0]] <= RXD_IN;
            end else begin
                par_bit_reg <= RXD_IN;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            brk_cnt_reg <= 2'h0;
        end else if (state_reg != ST_BREAK || !RXD_IN) begin
            brk_cnt_reg <= 2'h0;
        end else if (CRYSTAL_EDGE_IN) begin
            brk_cnt_reg <= brk_cnt_reg + 2'h1;
        end
    end

    // Data entries are never erased; a receiver reset moves pointers and clears the head slot status
    always_ff @(posedge CLK_SYS_IN) begin
        if (push_ok) begin
            data_mem[wr_ptr_reg] <= is_break ? DATA_ZERO : shift_reg;
            stat_mem[wr_ptr_reg] <= new_stat;
        end else if (RX_RESET_CMD_IN) begin
            stat_mem[rd_ptr_reg] <= STAT_ZERO;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rd_ptr_reg <= PTR_ZERO;
            wr_ptr_reg <= PTR_ZERO;
            count_reg <= PTR_ZERO;
        end else if (RX_RESET_CMD_IN) begin
            wr_ptr_reg <= rd_ptr_reg;
            count_reg <= PTR_ZERO;
        end else begin
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            if (push_ok) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            count_reg <= count_reg + 2'(push_ok) - 2'(pop);
        end
    end

    // Error sets win over a simultaneous reset-error command
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            block_acc_reg <= STAT_ZERO;
            overrun_reg <= 1'b0;
        end else begin
            block_acc_reg <= (ERROR_RESET_CMD_IN ? STAT_ZERO : block_acc_reg) | head_stat;
            overrun_reg <= (push && full && !pop) | (overrun_reg & ~ERROR_RESET_CMD_IN);
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rts_on_reg <= 1'b0;
            auto_neg_reg <= 1'b0;
        end else if (RTS_ASSERT_CMD_IN || RTS_NEGATE_CMD_IN) begin
            rts_on_reg <= RTS_ASSERT_CMD_IN;
            auto_neg_reg <= 1'b0;
        end else if (RX_RTS_CTRL_IN && start_valid && full && rts_on_reg) begin
            rts_on_reg <= 1'b0;
            auto_neg_reg <= 1'b1;
        end else if (auto_neg_reg && !full) begin
            rts_on_reg <= 1'b1;
            auto_neg_reg <= 1'b0;
        end
    end

    // Head copy lags the queue by one clock; hosts read it a cycle after a change
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rx_data_reg <= DATA_ZERO;
        end else begin
            rx_data_reg <= data_mem[rd_ptr_reg];
        end
    end

    arw_cos_detect u_cos (
        .clk_in(CLK_SYS_IN),
        .rst_b_in(RST_B_IN),
        .pin_in(MULTI_INPUT_PIN_IN),
        .enable_in(COS_ENABLE_IN),
        .sample_in(SAMPLE_38K_IN),
        .clear_in(COS_CLEAR_CMD_IN),
        .change_out(COS_STATUS_OUT)
    );

    assign RX_DATA_OUT = rx_data_reg;
    assign RX_CHAR_AVAILABLE_OUT = avail;
    assign RX_QUEUE_FULL_OUT = full;
    assign OVERRUN_OUT = overrun_reg;
    assign PARITY_ERROR_FLAG_OUT = shown_stat[STAT_PAR];
    assign FRAMING_ERROR_FLAG_OUT = shown_stat[STAT_FRM];
    assign RX_BREAK_OUT = shown_stat[STAT_BRK];
    assign RX_INT_REQ_OUT = RX_INT_SELECT_IN ? full : avail;
    assign REQUEST_TO_SEND_B_OUT = ~rts_on_reg;
    assign COS_INT_OUT = COS_STATUS_OUT & COS_MASK_IN;
endmodule : arw_receiver

// ===== bench/arw_remote_tx.sv
`timescale 1ns/10ps
module arw_remote_tx (
    input wire logic clk_in, // System clock
    output logic rxd_out, // Serial line, idle high
    output logic clk16_out, // 16X bit clock
    output logic clk1x_out // 1X bit clock, rises mid-bit
);
    logic [4:0] ph = 5'h00;
    initial begin
        rxd_out = 1'b1;
        clk16_out = 1'b0;
    end
    // One 16X edge per system cycle, so a bit lasts 32 cycles
    always @(negedge clk_in) begin
        clk16_out <= ~clk16_out;
        ph <= ph + 5'h01;
    end
    assign clk1x_out = ph[4];
    // In 1X mode bits must change on the falling edge of the 1X clock
    task automatic align_1x;
        for (int i = 0; i < 32 && ph != 5'h1F; i++) begin
            @(negedge clk_in);
        end
    endtask : align_1x
    task automatic hold_line(input logic v, input int n);
        rxd_out <= v;
        repeat (n) @(negedge clk_in);
    endtask : hold_line
    // Start, data LSB first, optional parity or address bit, one stop
    task automatic send_char(input logic [7:0] d, input int nb, input logic has_x,
        input logic x, input logic stop);
        hold_line(1'b0, 32);
        for (int i = 0; i < nb; i++) begin
            hold_line(d[i], 32);
        end
        if (has_x) begin
            hold_line(x, 32);
        end
        hold_line(stop, 32);
    endtask : send_char
endmodule : arw_remote_tx

// ===== bench/arw_receiver_properties.sv
`timescale 1ns/10ps
module arw_receiver_props (
    input wire logic CLK_SYS_IN, // Clock
    input wire logic RST_B_IN, // Reset, active low
    input wire logic RX_READ_IN, // Pop
    input wire logic RX_RESET_CMD_IN, // Receiver reset
    input wire logic RX_INT_SELECT_IN, // Interrupt source
    input wire logic RX_RTS_CTRL_IN, // Auto send request
    input wire logic RTS_ASSERT_CMD_IN, // Assert command
    input wire logic RTS_NEGATE_CMD_IN, // Negate command
    input wire logic COS_CLEAR_CMD_IN, // Clear command
    input wire logic SAMPLE_38K_IN, // Sample strobe
    input wire logic COS_MASK_IN, // Mask
    input wire logic RX_CHAR_AVAILABLE_OUT, // Available
    input wire logic RX_QUEUE_FULL_OUT, // Full
    input wire logic RX_INT_REQ_OUT, // Interrupt
    input wire logic REQUEST_TO_SEND_B_OUT, // Send request
    input wire logic COS_STATUS_OUT, // Change status
    input wire logic COS_INT_OUT // Change interrupt
);
    wire int_exp = RX_INT_SELECT_IN ? RX_QUEUE_FULL_OUT : RX_CHAR_AVAILABLE_OUT;
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_B_IN);
    a_full_has_char: assert property (RX_QUEUE_FULL_OUT |-> RX_CHAR_AVAILABLE_OUT)
        else $error("full flag without available flag");
    a_int_source_sel: assert property (RX_INT_REQ_OUT == int_exp)
        else $error("interrupt request not from selected flag");
    a_read_frees: assert property (RX_READ_IN && RX_QUEUE_FULL_OUT |=> !RX_QUEUE_FULL_OUT)
        else $error("read did not free a slot");
    a_reset_empties: assert property (
        RX_RESET_CMD_IN |=> !RX_CHAR_AVAILABLE_OUT && !RX_QUEUE_FULL_OUT)
        else $error("receiver reset left flags set");
    a_rts_assert_cmd: assert property (
        RTS_ASSERT_CMD_IN && !RTS_NEGATE_CMD_IN |=> !REQUEST_TO_SEND_B_OUT)
        else $error("assert command ignored");
    a_rts_negate_cmd: assert property (
        RTS_NEGATE_CMD_IN && !RTS_ASSERT_CMD_IN |=> REQUEST_TO_SEND_B_OUT)
        else $error("negate command ignored");
    a_rts_stays_on: assert property (
        !RX_RTS_CTRL_IN && !REQUEST_TO_SEND_B_OUT && !RTS_NEGATE_CMD_IN |=> !REQUEST_TO_SEND_B_OUT)
        else $error("send request dropped with auto control off");
    a_rts_auto_cause: assert property ($rose(REQUEST_TO_SEND_B_OUT) |->
        $past(RTS_NEGATE_CMD_IN) || $past(RX_RTS_CTRL_IN && RX_QUEUE_FULL_OUT))
        else $error("send request negated without cause");
    a_cos_int_mask: assert property (COS_INT_OUT == (COS_STATUS_OUT && COS_MASK_IN))
        else $error("change interrupt not status and mask");
    a_cos_clear: assert property (COS_CLEAR_CMD_IN && !SAMPLE_38K_IN |=> !COS_STATUS_OUT)
        else $error("change status not cleared");
    a_cos_on_sample: assert property ($rose(COS_STATUS_OUT) |-> $past(SAMPLE_38K_IN))
        else $error("change status set off a sample");
    c_full: cover property (RX_QUEUE_FULL_OUT);
    c_auto_rts: cover property ($rose(REQUEST_TO_SEND_B_OUT) && RX_QUEUE_FULL_OUT);
    c_cos_set: cover property ($rose(COS_STATUS_OUT));
endmodule : arw_receiver_props
bind arw_receiver arw_receiver_props u_props (
    .CLK_SYS_IN, .RST_B_IN, .RX_READ_IN, .RX_RESET_CMD_IN, .RX_INT_SELECT_IN,
    .RX_RTS_CTRL_IN, .RTS_ASSERT_CMD_IN, .RTS_NEGATE_CMD_IN, .COS_CLEAR_CMD_IN,
    .SAMPLE_38K_IN, .COS_MASK_IN, .RX_CHAR_AVAILABLE_OUT, .RX_QUEUE_FULL_OUT,
    .RX_INT_REQ_OUT, .REQUEST_TO_SEND_B_OUT, .COS_STATUS_OUT, .COS_INT_OUT
);

// ===== bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import arw_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, crys = 1'b0, crys_en = 1'b0;
    logic [1:0] bpc = 2'h3;
    logic [1:0] pmode = PMODE_NONE;
    logic ptype = 1'b0, blk = 1'b0, isel = 1'b0, rtsc = 1'b0, en = 1'b1;
    logic rxrst = 1'b0, errrst = 1'b0, rtsa = 1'b0, request_to_send_out = 1'b0, rd = 1'b0;
    logic multi_input_pin = 1'b1, cosen = 1'b0, s38 = 1'b0, cosclr = 1'b0, cmask = 1'b0;
    logic rxd, clk16, clk1x;
    logic m1x = 1'b0;
    logic [DATA_W-1:0] data;
    logic avail, full, ovr, pe, fe, brk, irq, rts_b, cos, cosint;
    int num_errors = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    // Crystal edges can be stopped to prove the break end waits for them
    always @(negedge clk) crys <= crys_en & ~crys;
    arw_remote_tx tx (.clk_in(clk), .rxd_out(rxd), .clk16_out(clk16), .clk1x_out(clk1x));
    arw_receiver DUT (
        .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .RXD_IN(rxd), .RX_CLK16_IN(clk16),
        .RX_CLK1X_IN(clk1x), .CLK_MODE_1X_IN(m1x), .CRYSTAL_EDGE_IN(crys),
        .BITS_PER_CHAR_IN(bpc), .PARITY_MODE_IN(pmode), .PARITY_TYPE_IN(ptype),
        .ERROR_MODE_BLOCK_IN(blk), .RX_INT_SELECT_IN(isel), .RX_RTS_CTRL_IN(rtsc),
        .RX_ENABLE_IN(en), .RX_RESET_CMD_IN(rxrst), .ERROR_RESET_CMD_IN(errrst),
        .RTS_ASSERT_CMD_IN(rtsa), .RTS_NEGATE_CMD_IN(request_to_send_out), .RX_READ_IN(rd),
        .MULTI_INPUT_PIN_IN(multi_input_pin), .COS_ENABLE_IN(cosen), .SAMPLE_38K_IN(s38),
        .COS_CLEAR_CMD_IN(cosclr), .COS_MASK_IN(cmask), .RX_DATA_OUT(data),
        .RX_CHAR_AVAILABLE_OUT(avail), .RX_QUEUE_FULL_OUT(full), .OVERRUN_OUT(ovr),
        .PARITY_ERROR_FLAG_OUT(pe), .FRAMING_ERROR_FLAG_OUT(fe), .RX_BREAK_OUT(brk),
        .RX_INT_REQ_OUT(irq), .REQUEST_TO_SEND_B_OUT(rts_b), .COS_STATUS_OUT(cos),
        .COS_INT_OUT(cosint)
    );
    task automatic chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    // Two falling edges let the flags and the next head data settle
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        @(negedge clk);
    endtask : pulse
    // Status first: the pop discards it with the data
    task automatic read_char(input logic [7:0] ed, input logic epe, input logic efe);
        chk1("parity flag", epe, pe);
        chk1("framing flag", efe, fe);
        chk8("data", ed, data);
        pulse(rd);
    endtask : read_char
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk1("send request", 1'b1, rts_b);
        bpc = 2'h0;
        for (int m = 0; m < 4; m++) begin
            pmode = m[1:0];
            tx.send_char(8'hFB, 5, m != 2, 1'b1, 1'b1);
            read_char(8'h1B, m != 2, 1'b0);
        end
        bpc = 2'h3;
        pmode = PMODE_NONE;
        tx.hold_line(1'b0, 14);
        tx.hold_line(1'b1, 400);
        chk1("available", 1'b0, avail);
        pulse(rtsa);
        chk1("send request", 1'b0, rts_b);
        rtsc = 1'b1;
        isel = 1'b1;
        for (int k = 0; k < 4; k++) begin
            tx.send_char(8'h31 + k[7:0], 8, 1'b0, 1'b0, 1'b1);
        end
        chk1("full", 1'b1, full);
        chk1("interrupt", 1'b1, irq);
        chk1("send request", 1'b1, rts_b);
        chk1("overrun", 1'b1, ovr);
        for (int k = 0; k < 3; k++) begin
            read_char(8'h31 + k[7:0], 1'b0, 1'b0);
            chk1("send request", 1'b0, rts_b);
        end
        chk1("available", 1'b0, avail);
        pulse(errrst);
        chk1("overrun", 1'b0, ovr);
        tx.send_char(8'h00, 8, 1'b0, 1'b0, 1'b0);
        tx.hold_line(1'b0, 400);
        chk1("break", 1'b1, brk);
        chk8("data", 8'h00, data);
        pulse(rd);
        tx.hold_line(1'b1, 40);
        tx.send_char(8'h66, 8, 1'b0, 1'b0, 1'b1);
        chk1("available", 1'b0, avail);
        crys_en = 1'b1;
        tx.hold_line(1'b1, 8);
        tx.send_char(8'h5A, 8, 1'b0, 1'b0, 1'b1);
        read_char(8'h5A, 1'b0, 1'b0);
        pmode = PMODE_WAKEUP;
        en = 1'b0;
        tx.send_char(8'h11, 8, 1'b1, 1'b0, 1'b1);
        chk1("available", 1'b0, avail);
        tx.send_char(8'h22, 8, 1'b1, 1'b1, 1'b1);
        read_char(8'h22, 1'b1, 1'b0);
        pmode = PMODE_NONE;
        en = 1'b1;
        fork
            tx.send_char(8'hFF, 8, 1'b0, 1'b0, 1'b1);
            begin
                repeat (20) @(negedge clk);
                en = 1'b0;
                repeat (40) @(negedge clk);
                en = 1'b1;
            end
        join
        chk1("available", 1'b0, avail);
        tx.send_char(8'h42, 8, 1'b0, 1'b0, 1'b1);
        read_char(8'h42, 1'b0, 1'b0);
        // Low stop, then the next start at once: only a half-bit restart catches it
        tx.send_char(8'h81, 8, 1'b0, 1'b0, 1'b0);
        tx.send_char(8'h3C, 8, 1'b0, 1'b0, 1'b1);
        read_char(8'h81, 1'b0, 1'b1);
        read_char(8'h3C, 1'b0, 1'b0);
        m1x = 1'b1;
        tx.align_1x();
        tx.send_char(8'hA5, 8, 1'b0, 1'b0, 1'b1);
        read_char(8'hA5, 1'b0, 1'b0);
        m1x = 1'b0;
        pmode = PMODE_WITH;
        blk = 1'b1;
        // Earlier break and framing entries would still sit in the accumulator
        pulse(errrst);
        tx.send_char(8'h01, 8, 1'b1, 1'b0, 1'b1);
        tx.send_char(8'h03, 8, 1'b1, 1'b0, 1'b1);
        read_char(8'h01, 1'b1, 1'b0);
        chk1("parity flag", 1'b1, pe);
        pulse(errrst);
        chk1("parity flag", 1'b0, pe);
        pulse(rxrst);
        chk1("available", 1'b0, avail);
        blk = 1'b0;
        tx.send_char(8'h44, 8, 1'b1, 1'b0, 1'b1);
        read_char(8'h44, 1'b0, 1'b0);
        cosen = 1'b1;
        cmask = 1'b1;
        multi_input_pin = 1'b0;
        pulse(s38);
        chk1("change of state", 1'b0, cos);
        pulse(s38);
        chk1("change of state", 1'b1, cos);
        chk1("change interrupt", 1'b1, cosint);
        pulse(cosclr);
        chk1("change of state", 1'b0, cos);
        pulse(request_to_send_out);
        chk1("send request", 1'b1, rts_b);
        end_sim();
    end
endmodule : tb_top
